// *** hw/wws_pkg.sv ***
// Package with constants and types for the windowed watchdog supervisor
package wws_pkg;
    // Oscillator ticks are derived from mclk by a divider standing for the RC oscillator
    localparam int OSC_DIV_DEFAULT = 100;
    // Power-on delay and watchdog period in oscillator ticks
    localparam int POR_TICKS_DEFAULT = 1000;
    localparam int PERIOD_TICKS_DEFAULT = 3000;
    // Window split in percent of the period that is closed
    localparam int CLOSED_PCT_LONG = 67;
    localparam int CLOSED_PCT_SHORT = 33;
    localparam int PCT_FULL = 100;
    // Good clears needed before enable goes active
    localparam logic [1:0] GOOD_CLEARS_NEEDED = 2'h3;
    // Periods without a clear before standby in the sleep detector variant
    localparam logic [1:0] SLEEP_MISSES = 2'h2;
    localparam logic [31:0] CNT_ZERO = 32'h00000000;

    typedef enum logic [2:0] {
        WWS_ST_LOW_SUPPLY,
        WWS_ST_POR_DELAY,
        WWS_ST_CLOSED,
        WWS_ST_OPEN,
        WWS_ST_STANDBY
    } wws_state_t;

    typedef struct packed {
        logic rst_out;
        logic rst_oe_n;
        logic en_n;
    } wws_pins_t;
endpackage : wws_pkg

// *** hw/wws_supervisor.sv ***
// Windowed watchdog supervisor with power-on reset and safety enable
// How it works
// - After the supply rises above threshold a power-on delay runs and only then reset releases.
// - While the supply is below threshold reset is driven low.
// - A clear in the closed window or no clear by the end of the open window forces a reset.
// - Software clears only in the open window, and any clear in the closed window resets.
// - The closed window is 67 or 33 percent of the period, picked by a build parameter.
// - Enable stays inactive after reset until three good clears have been made in a row.
// - With the sleep detector built in, missing clears send the block into standby.
// - Enable is a push-pull output that is low when enabled.
// - Reset is open drain and active low, pulling low to assert and releasing otherwise.
`timescale 1ns/1ps
module wws_supervisor
    import wws_pkg::*;
#(
    parameter int OSC_DIV = OSC_DIV_DEFAULT,
    parameter int POR_TICKS = POR_TICKS_DEFAULT,
    parameter int PERIOD_TICKS = PERIOD_TICKS_DEFAULT,
    parameter bit LONG_CLOSED = 1'b1,
    parameter bit SLEEP_DETECT = 1'b0
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic supply_ok,
    input wire logic watchdog_clear_in,
    output wws_pins_t pins,
    output logic standby
);
    localparam int CLOSED_PCT = LONG_CLOSED ? CLOSED_PCT_LONG : CLOSED_PCT_SHORT;
    localparam int CLOSED_TICKS = (PERIOD_TICKS * CLOSED_PCT) / PCT_FULL;
    localparam logic [31:0] OSC_LAST = 32'(OSC_DIV - 1);
    localparam logic [31:0] POR_LAST = 32'(POR_TICKS - 1);
    localparam logic [31:0] CLOSED_LAST = 32'(CLOSED_TICKS - 1);
    localparam logic [31:0] OPEN_LAST = 32'(PERIOD_TICKS - CLOSED_TICKS - 1);

    wws_state_t state, next_state;
    logic [31:0] div_cnt, next_div_cnt;
    logic [31:0] tick_cnt, next_tick_cnt;
    logic [1:0] good, next_good;
    logic [1:0] misses, next_misses;
    logic clr_prev, next_clr_prev;
    logic rst_low, next_rst_low;
    logic en_n, next_en_n;
    logic next_standby;
    logic tick;
    logic clr_pulse;

    // Tick phase runs free, so the first tick of a delay may come early by one divider period
    assign tick = (div_cnt == OSC_LAST);
    // A clear held high counts once, only on its rising edge
    assign clr_pulse = watchdog_clear_in & ~clr_prev;

    // Prescaler standing in for the resistor-tuned oscillator, plus the clear edge detector
    always_comb
    begin
        next_div_cnt = tick ? CNT_ZERO : div_cnt + 32'h00000001;
        next_clr_prev = watchdog_clear_in;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            div_cnt <= CNT_ZERO;
            clr_prev <= 1'b0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
            clr_prev <= next_clr_prev;
        end
    end

    // Supervisor sequence; timeouts and closed clears share the power-on delay path
    // Misses survive the power-on delay so two timeouts in a row can be seen
    always_comb
    begin
        next_state = state;
        next_tick_cnt = tick_cnt;
        next_good = good;
        next_misses = misses;
        if (!supply_ok)
        begin
            next_state = WWS_ST_LOW_SUPPLY;
            next_tick_cnt = CNT_ZERO;
            next_good = 2'h0;
            next_misses = 2'h0;
        end
        else
        begin
            case (state)
                WWS_ST_LOW_SUPPLY:
                begin
                    next_state = WWS_ST_POR_DELAY;
                    next_tick_cnt = CNT_ZERO;
                end
                WWS_ST_POR_DELAY:
                begin
                    if (tick)
                    begin
                        if (tick_cnt == POR_LAST)
                        begin
                            next_state = WWS_ST_CLOSED;
                            next_tick_cnt = CNT_ZERO;
                        end
                        else
                        begin
                            next_tick_cnt = tick_cnt + 32'h00000001;
                        end
                    end
                end
                WWS_ST_CLOSED:
                begin
                    if (clr_pulse)
                    begin
                        next_state = WWS_ST_POR_DELAY;
                        next_tick_cnt = CNT_ZERO;
                        next_good = 2'h0;
                    end
                    else if (tick)
                    begin
                        if (tick_cnt == CLOSED_LAST)
                        begin
                            next_state = WWS_ST_OPEN;
                            next_tick_cnt = CNT_ZERO;
                        end
                        else
                        begin
                            next_tick_cnt = tick_cnt + 32'h00000001;
                        end
                    end
                end
                WWS_ST_OPEN:
                begin
                    if (clr_pulse)
                    begin
                        next_state = WWS_ST_CLOSED;
                        next_tick_cnt = CNT_ZERO;
                        next_misses = 2'h0;
                        if (good != GOOD_CLEARS_NEEDED)
                        begin
                            next_good = good + 2'h1;
                        end
                    end
                    else if (tick && tick_cnt == OPEN_LAST)
                    begin
                        next_tick_cnt = CNT_ZERO;
                        next_good = 2'h0;
                        if (SLEEP_DETECT && misses == SLEEP_MISSES - 2'h1)
                        begin
                            next_state = WWS_ST_STANDBY;
                        end
                        else
                        begin
                            next_state = WWS_ST_POR_DELAY;
                            next_misses = misses + 2'h1;
                        end
                    end
                    else if (tick)
                    begin
                        next_tick_cnt = tick_cnt + 32'h00000001;
                    end
                end
                WWS_ST_STANDBY:
                begin
                    if (clr_pulse)
                    begin
                        next_state = WWS_ST_POR_DELAY;
                        next_tick_cnt = CNT_ZERO;
                        next_misses = 2'h0;
                    end
                end
                default:
                begin
                    next_state = WWS_ST_LOW_SUPPLY;
                end
            endcase
        end
        // Outputs follow the next state so they change on the edge that takes the event
        next_rst_low = (next_state == WWS_ST_LOW_SUPPLY) || (next_state == WWS_ST_POR_DELAY);
        next_standby = (next_state == WWS_ST_STANDBY);
        next_en_n = (next_good != GOOD_CLEARS_NEEDED) || next_rst_low;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state <= WWS_ST_LOW_SUPPLY;
            tick_cnt <= CNT_ZERO;
            good <= 2'h0;
            misses <= 2'h0;
            rst_low <= 1'b1;
            en_n <= 1'b1;
            standby <= 1'b0;
        end
        else
        begin
            state <= next_state;
            tick_cnt <= next_tick_cnt;
            good <= next_good;
            misses <= next_misses;
            rst_low <= next_rst_low;
            en_n <= next_en_n;
            standby <= next_standby;
        end
    end

    // Open drain: drive low only while asserting, enable low means driving
    assign pins.rst_out = 1'b0;
    assign pins.rst_oe_n = ~rst_low;
    assign pins.en_n = en_n;
endmodule : wws_supervisor

// *** test/wws_monitor.sv ***
// Port checker for the watchdog supervisor, bound into the design
`timescale 1ns/1ps
module wws_monitor
    import wws_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic supply_ok,
    input wire logic watchdog_clear_in,
    input wws_pins_t pins,
    input wire logic standby
);
    logic [5:0] quiet;
    logic [5:0] next_quiet;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_clear; $rose(watchdog_clear_in); endsequence
    sequence s_release; $rose(pins.rst_oe_n); endsequence
    // Cycles since release or the last clear
    always_comb next_quiet = (!pins.rst_oe_n || watchdog_clear_in || standby) ? 6'h00 :
        quiet + 6'h01;
    always_ff @(posedge mclk or posedge reset) quiet <= reset ? 6'h00 : next_quiet;
    a_low_supply: assert property (!supply_ok |=> !pins.rst_oe_n)
        else $error("reset released with supply low");
    a_por_hold: assert property ($rose(supply_ok) |=> !pins.rst_oe_n [*5])
        else $error("power-on delay too short");
    a_por_release: assert property ($rose(supply_ok) ##1 supply_ok [*8] ##1 supply_ok [*3]
        |-> pins.rst_oe_n) else $error("power-on delay too long");
    a_rst_drain: assert property (pins.rst_out == 1'b0)
        else $error("reset data not low");
    a_en_third: assert property ($fell(pins.en_n) |-> $past(watchdog_clear_in)
        && !$past(watchdog_clear_in, 2)) else $error("enable without clear");
    a_en_cleared: assert property (!pins.rst_oe_n |-> pins.en_n)
        else $error("enable active in reset");
    a_closed_clear: assert property (s_release ##[1:10] s_clear |=> !pins.rst_oe_n)
        else $error("closed clear missed");
    a_wd_restart: assert property (s_clear ##1 pins.rst_oe_n ##[1:9] s_clear
        |=> !pins.rst_oe_n) else $error("period not restarted");
    a_late_timeout: assert property (quiet <= 6'h1A)
        else $error("timeout missed");
    a_standby_held: assert property (standby |-> pins.rst_oe_n && pins.en_n)
        else $error("standby with reset or enable active");
endmodule : wws_monitor
bind wws_supervisor wws_monitor i_wws_monitor (.mclk(mclk), .reset(reset),
    .supply_ok(supply_ok), .watchdog_clear_in(watchdog_clear_in), .pins(pins),
    .standby(standby));

// *** test/wws_mcu_model.sv ***
// Microcontroller model that pulses the watchdog clear
`timescale 1ns/1ps
module wws_mcu_model (
    input wire logic mclk,
    input wire logic rst_line,
    input wire logic run,
    input wire logic [7:0] gap,
    output logic clr
);
    logic [7:0] cnt = 8'h00;
    initial clr = 1'b0;
    // One-cycle clear gap+1 cycles after release, gap+2 cycles after the last clear rose
    always @(posedge mclk)
    begin
        clr <= 1'b0;
        if (!rst_line || clr)
            cnt <= 8'h00;
        else if (cnt == gap && run)
            clr <= 1'b1;
        else
            cnt <= cnt + 8'h01;
    end
endmodule : wws_mcu_model

// *** test/testbench.sv ***
// Self-checking bench for the watchdog supervisor
`timescale 1ns/1ps
module testbench;
    import wws_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic supply_ok = 1'b0;
    logic run = 1'b0;
    logic [7:0] gap = 8'h11;
    logic clr;
    logic standby;
    wire rst_line;
    wws_pins_t pins;
    logic supply2 = 1'b0;
    logic clr2 = 1'b0;
    logic standby2;
    wire rst2;
    wws_pins_t pins2;
    int n_fail = 0;
    int compares = 0;
    int n;
    assign rst_line = pins.rst_oe_n ? 1'b1 : pins.rst_out;
    wws_supervisor #(.OSC_DIV(2), .POR_TICKS(4), .PERIOD_TICKS(12)) i_wws_supervisor (
        .mclk(mclk), .reset(reset), .supply_ok(supply_ok), .watchdog_clear_in(clr),
        .pins(pins), .standby(standby));
    assign rst2 = pins2.rst_oe_n ? 1'b1 : pins2.rst_out;
    wws_supervisor #(.OSC_DIV(2), .POR_TICKS(4), .PERIOD_TICKS(12), .SLEEP_DETECT(1'b1))
        i_wws_supervisor_sleep (.mclk(mclk), .reset(reset), .supply_ok(supply2),
        .watchdog_clear_in(clr2), .pins(pins2), .standby(standby2));
    wws_mcu_model i_wws_mcu_model (.mclk(mclk), .rst_line(rst_line), .run(run), .gap(gap),
        .clr(clr));
    initial forever #50 mclk = ~mclk;
    task give_verdict;
        $display("n_fail %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task check_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %b got %b", what, exp, got);
        end
    endtask : check_bit
    task check_span(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi)
        begin
            n_fail++;
            $display("BAD %s exp %0d..%0d got %0d", what, lo, hi, got);
        end
    endtask : check_span
    task step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : step
    // Cycles until clear (sel) or reset line reaches lvl
    task wait_for(input bit sel, input logic lvl, input int lim);
        n = 0;
        while ((sel ? clr : rst_line) !== lvl)
        begin
            step(1);
            n++;
            if (n > lim)
            begin
                n_fail++;
                give_verdict();
            end
        end
    endtask : wait_for
    // Sleep variant: two silent periods lead to standby, a clear wakes it
    task sleep_scenario;
        int w;
        w = 0;
        supply2 = 1'b1;
        while (standby2 !== 1'b1)
        begin
            step(1);
            w++;
            if (w > 90)
            begin
                n_fail++;
                give_verdict();
            end
        end
        check_span("sleep cycles", 55, 75, w);
        check_bit("rst in standby", 1'b1, rst2);
        check_bit("en in standby", 1'b1, pins2.en_n);
        clr2 = 1'b1;
        step(1);
        check_bit("standby wake", 1'b0, standby2);
        check_bit("rst on wake", 1'b0, rst2);
        clr2 = 1'b0;
    endtask : sleep_scenario
    initial
    begin
        step(16);
        reset = 1'b0;
        step(2);
        check_bit("rst low supply", 1'b0, rst_line);
        check_bit("rst data", 1'b0, pins.rst_out);
        supply_ok = 1'b1;
        wait_for(1'b0, 1'b1, 30);
        check_span("por cycles", 6, 11, n);
        run = 1'b1;
        for (int k = 1; k <= 3; k++)
        begin
            wait_for(1'b1, 1'b1, 40);
            step(2);
            check_bit("en after clear", k < 3, pins.en_n);
        end
        check_bit("rst held", 1'b1, rst_line);
        gap = 8'h05;
        wait_for(1'b0, 1'b0, 40);
        check_span("early reset", 3, 9, n);
        check_bit("en after wd reset", 1'b1, pins.en_n);
        gap = 8'h11;
        wait_for(1'b0, 1'b1, 30);
        check_span("wd por cycles", 6, 11, n);
        wait_for(1'b1, 1'b1, 40);
        run = 1'b0;
        step(2);
        check_bit("en one clear", 1'b1, pins.en_n);
        wait_for(1'b0, 1'b0, 40);
        check_span("late reset", 18, 25, n);
        wait_for(1'b0, 1'b1, 30);
        supply_ok = 1'b0;
        step(1);
        check_bit("rst on drop", 1'b0, rst_line);
        check_bit("standby", 1'b0, standby);
        sleep_scenario();
        give_verdict();
    end
endmodule : testbench
